// ---- rtl/dsd_decoder.sv ----
// data-space decoder with io bit access, gp registers and eeprom port
// Notes on behaviour
// - 0x0000-0x001F selects working registers
// - 0x0020-0x005F selects standard io registers
// - 0x60-0xFF extended io, load/store only
// - sram from 0x0100 to size-dependent end
// - every sram access takes two cycles
// - io address plus 0x20 gives data address
// - bit set/clear/test only at io 0x00-0x1F
// - bit ops touch only the addressed bit
// - some flags clear on writing one
// - direct whole space, displacement up to 63
// - pre-decrement and post-increment pointer by one
// - three general purpose io registers
// - separate byte-addressed eeprom, size by device
// - eeprom registers live in io space
// - eeprom read stalls cpu four cycles
// - eeprom write stalls cpu two cycles
// - self-timed write with busy status bit
// - reset does not abort running write
// - program flash 16-bit words, pc width
// - write only within four cycles of enable
// - read data lands in data register immediately
`timescale 1ns/100ps
module dsd_decoder #(
  parameter int EE_DEPTH = 512,
  parameter int EE_AW = 9,
  parameter int SRAM_BYTES = 1024,
  parameter int PC_WIDTH = 13,
  parameter int EE_WRITE_CYC = dsd_pkg::EE_WRITE_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [2:0] ptr_mode,
  input wire logic [15:0] ptr_base,
  input wire logic [5:0] ptr_disp,
  input wire logic io_req,
  input wire logic io_we,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic bit_req,
  input wire logic [1:0] bit_op,
  input wire logic [2:0] bit_idx,
  input wire logic [PC_WIDTH-1:0] program_counter,
  input wire logic [7:0] flag_set,
  output logic [15:0] eff_addr,
  output logic [15:0] ptr_next,
  output dsd_pkg::dsd_sel_t sel,
  output logic [7:0] rdata,
  output logic sram_done,
  output logic bit_test,
  output logic bit_illegal,
  output logic cpu_run_en,
  output logic [PC_WIDTH-1:0] flash_word_addr,
  output logic [7:0] flags
);
  import dsd_pkg::*;
  // ***********************************
  // address decode
  // ***********************************
  localparam logic [15:0] SRAM_LAST = 16'(SRAM_FIRST + SRAM_BYTES - 1);
  function automatic dsd_sel_t decode(input logic [15:0] a);
    if (a <= REGFILE_LAST) return SEL_REGFILE;
    if (a <= STDIO_LAST) return SEL_STDIO;
    if (a <= EXTIO_LAST) return SEL_EXTIO;
    if (a <= SRAM_LAST) return SEL_SRAM;
    return SEL_NONE;
  endfunction : decode
  // ptr_mode: 0 direct, 1 indirect, 2 displacement, 3 pre-dec, 4 post-inc
  wire [15:0] disp_addr = ptr_base + {10'h000, ptr_disp};
  wire [15:0] dec_addr = ptr_base - 16'h0001;
  wire [15:0] inc_addr = ptr_base + 16'h0001;
  assign eff_addr = (ptr_mode == 3'd0) ? mem_addr :
                    (ptr_mode == 3'd2) ? disp_addr :
                    (ptr_mode == 3'd3) ? dec_addr : ptr_base;
  assign ptr_next = (ptr_mode == 3'd3) ? dec_addr :
                    (ptr_mode == 3'd4) ? inc_addr : ptr_base;
  wire [15:0] io_as_data = {8'h00, 2'b00, io_addr} + {8'h00, IO_TO_DATA_OFFSET};
  assign sel = decode(io_req ? io_as_data : eff_addr);
  // io register index for both paths; extended io never reached by io_req
  wire mem_io = mem_req && (sel == SEL_STDIO);
  wire [15:0] mem_io_idx = eff_addr - {8'h00, IO_TO_DATA_OFFSET};
  // bit ops name their register by io_addr, like short io accesses
  wire [5:0] io_idx = (io_req || bit_req) ? io_addr : mem_io_idx[5:0];
  wire io_wr = (io_req && io_we) || (mem_io && mem_we);
  wire [7:0] io_wd = io_req ? io_wdata : mem_wdata;
  assign flash_word_addr = program_counter;
  // ***********************************
  // sram with two-cycle access
  // ***********************************
  logic [7:0] sram_mem [SRAM_BYTES];
  logic sram_busy_r;
  logic [7:0] sram_q_r;
  wire sram_go = mem_req && (sel == SEL_SRAM) && !sram_busy_r;
  wire [15:0] sram_idx = eff_addr - SRAM_FIRST;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) sram_busy_r <= 1'b0;
    else sram_busy_r <= sram_go;
  end
  always_ff @(posedge core_clk) begin
    if (sram_go && mem_we) sram_mem[sram_idx[$clog2(SRAM_BYTES)-1:0]] <= mem_wdata;
    if (sram_go) sram_q_r <= sram_mem[sram_idx[$clog2(SRAM_BYTES)-1:0]];
  end
  assign sram_done = sram_busy_r;
  // ***********************************
  // general purpose registers and bit ops
  // ***********************************
  logic [7:0] gp_r [3];
  wire bit_ok = bit_req && (io_addr <= IO_BIT_LAST);
  assign bit_illegal = bit_req && !bit_ok;
  wire [7:0] bit_mask = 8'h01 << bit_idx;
  localparam logic [5:0] GP_OFS [3] = '{OFS_GP0, OFS_GP1, OFS_GP2};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_gp
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) gp_r[g] <= RESET_VALUE_BYTE;
        else if (io_wr && io_idx == GP_OFS[g]) gp_r[g] <= io_wd;
        else if (bit_ok && bit_op[1] == 1'b0 && io_addr == GP_OFS[g]) begin
          gp_r[g] <= bit_op[0] ? (gp_r[g] | bit_mask) : (gp_r[g] & ~bit_mask);
        end
      end
    end
  endgenerate
  // flags: write-one-to-clear register at gp0 neighbour, set wins over clear
  localparam logic [5:0] OFS_FLAGS = 6'h1D;
  logic [7:0] flags_r;
  wire [7:0] flag_clr = (io_wr && io_idx == OFS_FLAGS) ? io_wd :
    (bit_ok && bit_op == 2'b01 && io_addr == OFS_FLAGS) ? bit_mask : 8'h00;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) flags_r <= RESET_VALUE_BYTE;
    else flags_r <= (flags_r & ~flag_clr) | flag_set;
  end
  assign flags = flags_r;
  // ***********************************
  // eeprom port
  // ***********************************
  logic [7:0] ee_mem [EE_DEPTH];
  logic [EE_AW-1:0] ee_addr_r;
  logic [7:0] ee_data_r;
  logic [1:0] ee_mode_r;
  logic ee_rdyie_r, ee_mwe_r, ee_busy_r;
  logic [2:0] mwe_cnt_r;
  logic [2:0] stall_r;
  logic [31:0] wr_cnt_r;
  logic wr_seen_r = 1'b0;
  // write target latched at strobe so a reset cannot redirect it
  logic [EE_AW-1:0] wr_addr_r;
  logic [7:0] wr_data_r;
  wire ctrl_wr = io_wr && io_idx == OFS_EE_CTRL;
  wire [7:0] ctrl_set = ctrl_wr ? io_wd :
    (bit_ok && bit_op == 2'b01 && io_addr == OFS_EE_CTRL) ? bit_mask : 8'h00;
  wire rd_go = ctrl_set[CTRL_READ_BIT] && !ee_busy_r;
  wire wr_go = ctrl_set[CTRL_WSTROBE_BIT] && ee_mwe_r && !ee_busy_r;
  wire mwe_go = ctrl_set[CTRL_MWE_BIT] && !ctrl_set[CTRL_WSTROBE_BIT];
  wire [7:0] ee_ctrl_val = {2'b00, ee_mode_r, ee_rdyie_r, ee_mwe_r, ee_busy_r, 1'b0};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ee_addr_r <= '0;
      ee_data_r <= RESET_VALUE_BYTE;
      ee_rdyie_r <= 1'b0;
      ee_mwe_r <= 1'b0;
      mwe_cnt_r <= '0;
      stall_r <= '0;
    end else begin
      if (io_wr && io_idx == OFS_EE_ADDR_LO && !ee_busy_r) ee_addr_r[7:0] <= io_wd;
      if (io_wr && io_idx == OFS_EE_ADDR_HI && !ee_busy_r) ee_addr_r[EE_AW-1:8] <= io_wd[EE_AW-9:0];
      if (rd_go) ee_data_r <= ee_mem[ee_addr_r];
      else if (io_wr && io_idx == OFS_EE_DATA) ee_data_r <= io_wd;
      if (ctrl_wr) ee_rdyie_r <= io_wd[CTRL_RDYIE_BIT];
      if (mwe_go) begin
        ee_mwe_r <= 1'b1;
        mwe_cnt_r <= 3'(EE_MWE_WINDOW);
      end else if (wr_go || mwe_cnt_r == 3'd1) begin
        ee_mwe_r <= 1'b0;
        mwe_cnt_r <= '0;
      end else if (mwe_cnt_r != 3'd0) mwe_cnt_r <= mwe_cnt_r - 3'd1;
      if (rd_go) stall_r <= 3'(EE_READ_STALL);
      else if (wr_go) stall_r <= 3'(EE_WRITE_STALL);
      else if (stall_r != 3'd0) stall_r <= stall_r - 3'd1;
    end
  end
  assign cpu_run_en = (stall_r == 3'd0);
  // busy flag, counter and mode survive reset while programming
  always_ff @(posedge core_clk) begin
    if (!wr_seen_r) begin
      ee_busy_r <= 1'b0;
      ee_mode_r <= 2'b00;
      wr_cnt_r <= '0;
    end else if (wr_go) begin
      ee_busy_r <= 1'b1;
      wr_cnt_r <= 32'(EE_WRITE_CYC);
      wr_addr_r <= ee_addr_r;
      wr_data_r <= ee_data_r;
    end else if (ee_busy_r) begin
      if (wr_cnt_r == 32'd1) ee_busy_r <= 1'b0;
      wr_cnt_r <= wr_cnt_r - 32'd1;
    end else if (!nrst) ee_mode_r <= 2'b00;
    else if (ctrl_wr) ee_mode_r <= io_wd[CTRL_MODE_LSB+:2];
    if (ee_busy_r && wr_cnt_r == 32'd1) begin
      case (ee_mode_r)
        2'b01: ee_mem[wr_addr_r] <= 8'hFF;
        2'b10: ee_mem[wr_addr_r] <= ee_mem[wr_addr_r] & wr_data_r;
        default: ee_mem[wr_addr_r] <= wr_data_r;
      endcase
    end
  end
  // one-time power-up marker so busy has a defined start value
  always_ff @(posedge core_clk) wr_seen_r <= 1'b1;
  // ***********************************
  // read mux
  // ***********************************
  wire [7:0] io_rd = (io_idx == OFS_EE_CTRL) ? ee_ctrl_val :
    (io_idx == OFS_EE_DATA) ? ee_data_r :
    (io_idx == OFS_EE_ADDR_LO) ? ee_addr_r[7:0] :
    (io_idx == OFS_EE_ADDR_HI) ? 8'(ee_addr_r[EE_AW-1:8]) :
    (io_idx == OFS_FLAGS) ? flags_r :
    (io_idx == OFS_GP0) ? gp_r[0] :
    (io_idx == OFS_GP1) ? gp_r[1] :
    (io_idx == OFS_GP2) ? gp_r[2] : 8'h00;
  // rdata holds between requests
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) rdata <= 8'h00;
    else if (sram_busy_r) rdata <= sram_q_r;
    else if (io_req || mem_io || bit_req) rdata <= io_rd;
  end
  assign bit_test = bit_ok && io_rd[bit_idx] == bit_op[0];
  // ***********************************
  // assertions
  // ***********************************
  a_regfile_sel: assert property (@(posedge core_clk) disable iff (!nrst)
    (!io_req && eff_addr <= REGFILE_LAST) |-> sel == SEL_REGFILE) else $error("regfile decode");
  a_stdio_sel: assert property (@(posedge core_clk) disable iff (!nrst)
    (!io_req && eff_addr >= STDIO_FIRST && eff_addr <= STDIO_LAST) |-> sel == SEL_STDIO)
    else $error("stdio decode");
  a_io_offset: assert property (@(posedge core_clk) disable iff (!nrst)
    io_req |-> sel != SEL_EXTIO) else $error("io reached extended");
  a_sram_two: assert property (@(posedge core_clk) disable iff (!nrst)
    sram_go |=> sram_done ##1 !sram_done || sram_go) else $error("sram timing");
  a_bit_range: assert property (@(posedge core_clk) disable iff (!nrst)
    (bit_req && io_addr > IO_BIT_LAST) |-> bit_illegal) else $error("bit range");
  a_read_stall: assert property (@(posedge core_clk) disable iff (!nrst)
    rd_go |=> !cpu_run_en [*4] ##1 cpu_run_en || $past(rd_go)) else $error("read stall");
  a_write_stall: assert property (@(posedge core_clk) disable iff (!nrst)
    (wr_go && !rd_go) |=> !cpu_run_en [*2]) else $error("write stall");
  a_mwe_window: assert property (@(posedge core_clk) disable iff (!nrst)
    mwe_go |-> ##[1:5] !ee_mwe_r) else $error("enable window");
  a_ptr_step: assert property (@(posedge core_clk) disable iff (!nrst)
    ptr_mode == 3'd4 |-> ptr_next == ptr_base + 16'h0001) else $error("post inc");
  a_extio_sel:
    assert property (@(posedge core_clk) disable iff (!nrst)
    (!io_req && eff_addr >= EXTIO_FIRST && eff_addr <= EXTIO_LAST) |-> sel == SEL_EXTIO)
    else $error("extio decode");
  a_sram_sel:
    assert property (@(posedge core_clk) disable iff (!nrst)
    (!io_req && eff_addr >= SRAM_FIRST && eff_addr <= SRAM_LAST) |-> sel == SEL_SRAM)
    else $error("sram decode");
  a_io_map:
    assert property (@(posedge core_clk) disable iff (!nrst)
    io_req |-> sel == SEL_STDIO)
    else $error("io map");
  a_ptr_dec:
    assert property (@(posedge core_clk) disable iff (!nrst)
    ptr_mode == 3'd3 |-> (ptr_next == ptr_base - 16'h0001) && (eff_addr == ptr_next))
    else $error("pre dec");
  a_bit_only:
    assert property (@(posedge core_clk) disable iff (!nrst)
    (bit_ok && bit_op[1] == 1'b0 && io_addr == OFS_GP0 && !io_wr) |=> ((gp_r[0] ^ $past(gp_r[0])) & ~$past(bit_mask)) == 8'h00)
    else $error("bit op spill");
  a_flag_set_wins:
    assert property (@(posedge core_clk) disable iff (!nrst)
    flag_set[0] |=> flags_r[0])
    else $error("flag set lost");
  // ***********************************
  // eeprom checks
  // ***********************************
  a_busy_hold:
    assert property (@(posedge core_clk)
    (ee_busy_r && wr_cnt_r > 32'd1) |=> ee_busy_r)
    else $error("write cut short");
  a_wr_gate:
    assert property (@(posedge core_clk) disable iff (!nrst)
    (ctrl_set[CTRL_WSTROBE_BIT] && !ee_mwe_r && !ee_busy_r) |=> !ee_busy_r)
    else $error("ungated write");
  a_mwe_clear:
    assert property (@(posedge core_clk) disable iff (!nrst)
    (ee_mwe_r && mwe_cnt_r == 3'd1 && !mwe_go) |=> !ee_mwe_r)
    else $error("enable not timed out");
  a_addr_lock:
    assert property (@(posedge core_clk) disable iff (!nrst)
    ee_busy_r |=> $stable(ee_addr_r))
    else $error("address moved while busy");
  c_sram: cover property (@(posedge core_clk) sram_go && mem_we);
  c_ee_read: cover property (@(posedge core_clk) rd_go);
  c_ee_write: cover property (@(posedge core_clk) wr_go);
  c_bit_set: cover property (@(posedge core_clk) bit_ok && bit_op == 2'b01);
  c_late_strobe: cover property (@(posedge core_clk) ctrl_set[CTRL_WSTROBE_BIT] && !ee_mwe_r);
endmodule : dsd_decoder

// ---- rtl/dsd_pkg.sv ----
// package: data-space decoder constants, register offsets and timing counts
package dsd_pkg;
  // data-space window bounds
  localparam logic [15:0] REGFILE_LAST = 16'h001F;
  localparam logic [15:0] STDIO_FIRST = 16'h0020;
  localparam logic [15:0] STDIO_LAST = 16'h005F;
  localparam logic [15:0] EXTIO_FIRST = 16'h0060;
  localparam logic [15:0] EXTIO_LAST = 16'h00FF;
  localparam logic [15:0] SRAM_FIRST = 16'h0100;
  localparam logic [15:0] SRAM_LAST_DEFAULT = 16'h04FF;
  localparam logic [7:0] IO_TO_DATA_OFFSET = 8'h20;
  localparam logic [5:0] IO_BIT_LAST = 6'h1F;
  // io addresses
  localparam logic [5:0] OFS_EE_CTRL = 6'h1F;
  localparam logic [5:0] OFS_EE_DATA = 6'h20;
  localparam logic [5:0] OFS_EE_ADDR_LO = 6'h21;
  localparam logic [5:0] OFS_EE_ADDR_HI = 6'h22;
  localparam logic [5:0] OFS_GP0 = 6'h1E;
  localparam logic [5:0] OFS_GP1 = 6'h2A;
  localparam logic [5:0] OFS_GP2 = 6'h2B;
  // control field positions
  localparam int CTRL_READ_BIT = 0;
  localparam int CTRL_WSTROBE_BIT = 1;
  localparam int CTRL_MWE_BIT = 2;
  localparam int CTRL_RDYIE_BIT = 3;
  localparam int CTRL_MODE_LSB = 4;
  localparam logic [7:0] CTRL_WRITABLE_MASK = 8'h3F;
  localparam logic [7:0] RESET_VALUE_BYTE = 8'h00;
  // timing counts in cycles; eeprom write time in ms, clock in MHz
  localparam int SRAM_ACCESS_CYCLES = 2;
  localparam int EE_READ_STALL = 4;
  localparam int EE_WRITE_STALL = 2;
  localparam int EE_MWE_WINDOW = 4;
  localparam real EE_WRITE_TIME_MS = 3.3;
  localparam real CLK_MHZ = 125.0;
  localparam int EE_WRITE_CYCLES = int'(EE_WRITE_TIME_MS * CLK_MHZ * 1000.0);
  typedef enum logic [2:0] {SEL_NONE, SEL_REGFILE, SEL_STDIO, SEL_EXTIO, SEL_SRAM} dsd_sel_t;
endpackage : dsd_pkg

// ---- tb/dsd_cpu_model.sv ----
// cpu-side request driver feeding the data-space decoder
`timescale 1ns/100ps
module dsd_cpu_model (
  input wire logic core_clk,
  input wire logic [7:0] rdata,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic [2:0] ptr_mode,
  output logic [15:0] ptr_base,
  output logic [5:0] ptr_disp,
  output logic io_req,
  output logic io_we,
  output logic [5:0] io_addr,
  output logic [7:0] io_wdata,
  output logic bit_req,
  output logic [1:0] bit_op,
  output logic [2:0] bit_idx
);
  import dsd_pkg::*;
  initial begin
    {mem_req, mem_we, mem_addr, mem_wdata, ptr_mode, ptr_base, ptr_disp} = '0;
    {io_req, io_we, io_addr, io_wdata, bit_req, bit_op, bit_idx} = '0;
  end
  task go(input logic [2:0] m, input logic [15:0] b, input logic [5:0] d, input logic [15:0] a,
    input logic we, input logic [7:0] wd);
    {ptr_mode, ptr_base, ptr_disp, mem_addr, mem_we, mem_wdata, mem_req} = {m, b, d, a, we, wd, 1'b1};
  endtask : go
  task iset(input logic we, input logic [5:0] a, input logic [7:0] d);
    {io_we, io_addr, io_wdata, io_req} = {we, a, d, 1'b1};
  endtask : iset
  task bset(input logic [5:0] a, input logic [1:0] op, input logic [2:0] i);
    {io_addr, bit_op, bit_idx, bit_req} = {a, op, i, 1'b1};
  endtask : bset
  // request held over one taking edge, answer read n edges later
  task done(input int n, output logic [7:0] r);
    @(posedge core_clk);
    #1;
    {mem_req, mem_we, io_req, io_we, bit_req} = '0;
    repeat (n) @(posedge core_clk);
    #1;
    r = rdata;
  endtask : done
  // unlock then strobe one idle cycle later, reserved bits zero
  task ee_write();
    logic [7:0] x;
    iset(1'b1, OFS_EE_CTRL, 8'h04);
    done(1, x);
    iset(1'b1, OFS_EE_CTRL, 8'h02);
    done(1, x);
  endtask : ee_write
endmodule : dsd_cpu_model

// ---- tb/tb.sv ----
// self-checking bench for the data-space decoder
`timescale 1ns/100ps
module tb;
  import dsd_pkg::*;
  typedef struct {logic [2:0] m; logic [15:0] b; logic [5:0] d; logic [15:0] a; logic [15:0] e; logic [15:0] p;
    dsd_sel_t s;} dsd_row_t;
  logic core_clk, nrst, mem_req, mem_we, io_req, io_we, bit_req, sram_done, bit_test, bit_illegal, cpu_run_en;
  logic [15:0] mem_addr, ptr_base, eff_addr, ptr_next;
  logic [7:0] mem_wdata, io_wdata, flag_set, rdata, flags, r;
  logic [5:0] ptr_disp, io_addr;
  logic [2:0] ptr_mode, bit_idx;
  logic [1:0] bit_op;
  logic [12:0] program_counter, flash_word_addr;
  dsd_sel_t sel;
  int err_total, n_compared, lowcnt, cyc;
  dsd_row_t rows[12];
  dsd_decoder #(.EE_WRITE_CYC(20)) dut (.core_clk, .nrst, .mem_req, .mem_we, .mem_addr, .mem_wdata, .ptr_mode,
    .ptr_base, .ptr_disp, .io_req, .io_we, .io_addr, .io_wdata, .bit_req, .bit_op, .bit_idx, .program_counter,
    .flag_set, .eff_addr, .ptr_next, .sel, .rdata, .sram_done, .bit_test, .bit_illegal, .cpu_run_en,
    .flash_word_addr, .flags);
  dsd_cpu_model cpu (.core_clk, .rdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .ptr_mode, .ptr_base,
    .ptr_disp, .io_req, .io_we, .io_addr, .io_wdata, .bit_req, .bit_op, .bit_idx);
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task give_verdict();
    if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task iow(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] x;
    cpu.iset(1'b1, a, d);
    cpu.done(1, x);
  endtask : iow
  task ior(input logic [5:0] a, output logic [7:0] d);
    cpu.iset(1'b0, a, 8'h00);
    cpu.done(1, d);
  endtask : ior
  task wait_idle();
    for (int k = 0; k < 40; k++) begin
      ior(OFS_EE_CTRL, r);
      if (r[CTRL_WSTROBE_BIT] === 1'b0) break;
    end
  endtask : wait_idle
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // stall cycle count and hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cpu_run_en === 1'b0) lowcnt++;
    if (cyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    rows = '{'{3'h0, 16'h0, 6'h0, 16'h0000, 16'h0000, 16'h0, SEL_REGFILE},
      '{3'h0, 16'h0, 6'h0, 16'h001F, 16'h001F, 16'h0, SEL_REGFILE}, '{3'h0, 16'h0, 6'h0, 16'h0020, 16'h0020, 16'h0, SEL_STDIO},
      '{3'h0, 16'h0, 6'h0, 16'h005F, 16'h005F, 16'h0, SEL_STDIO}, '{3'h0, 16'h0, 6'h0, 16'h0060, 16'h0060, 16'h0, SEL_EXTIO},
      '{3'h0, 16'h0, 6'h0, 16'h00FF, 16'h00FF, 16'h0, SEL_EXTIO}, '{3'h0, 16'h0, 6'h0, 16'h0100, 16'h0100, 16'h0, SEL_SRAM},
      '{3'h0, 16'h0, 6'h0, 16'h04FF, 16'h04FF, 16'h0, SEL_SRAM}, '{3'h0, 16'h0, 6'h0, 16'h0500, 16'h0500, 16'h0, SEL_NONE},
      '{3'h2, 16'h0100, 6'h3F, 16'h0, 16'h013F, 16'h0, SEL_SRAM},
      '{3'h3, 16'h0200, 6'h0, 16'h0, 16'h01FF, 16'h01FF, SEL_SRAM}, '{3'h4, 16'h0200, 6'h0, 16'h0, 16'h0200, 16'h0201, SEL_SRAM}};
    nrst = 1'b0;
    flag_set = 8'h00;
    program_counter = 13'h1ABC;
    repeat (20) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    chk("flash_word_addr", 16'h1ABC, 16'(flash_word_addr));
    foreach (rows[i]) begin
      cpu.go(rows[i].m, rows[i].b, rows[i].d, rows[i].a, 1'b0, 8'h00);
      #1;
      chk("eff_addr", rows[i].e, eff_addr);
      chk("sel", 16'(rows[i].s), 16'(sel));
      if (rows[i].m > 3'h2) chk("ptr_next", rows[i].p, ptr_next);
      cpu.done(3, r);
    end
    cpu.go(3'h0, 16'h0, 6'h0, 16'h0123, 1'b1, 8'hA5);
    cpu.done(0, r);
    chk("sram_done", 16'h1, 16'(sram_done));
    @(posedge core_clk);
    #1;
    chk("sram_done end", 16'h0, 16'(sram_done));
    cpu.go(3'h0, 16'h0, 6'h0, 16'h0123, 1'b0, 8'h00);
    cpu.done(3, r);
    chk("sram byte", 16'hA5, 16'(r));
    iow(OFS_GP1, 8'h3C);
    cpu.go(3'h0, 16'h0, 6'h0, 16'(OFS_GP1) + 16'(IO_TO_DATA_OFFSET), 1'b0, 8'h00);
    cpu.done(3, r);
    chk("io as data", 16'h3C, 16'(r));
    iow(OFS_GP0, 8'h81);
    cpu.bset(OFS_GP0, 2'b01, 3'h2);
    cpu.done(1, r);
    cpu.bset(OFS_GP0, 2'b00, 3'h7);
    cpu.done(1, r);
    ior(OFS_GP0, r);
    chk("gp0 bits", 16'h05, 16'(r));
    cpu.bset(OFS_GP0, 2'b11, 3'h0);
    #1;
    chk("bit_test", 16'h1, 16'(bit_test));
    cpu.done(1, r);
    cpu.bset(OFS_GP1, 2'b01, 3'h0);
    #1;
    chk("bit_illegal", 16'h1, 16'(bit_illegal));
    cpu.done(1, r);
    flag_set = 8'h09;
    @(posedge core_clk);
    #1;
    flag_set = 8'h00;
    cpu.bset(6'h1D, 2'b01, 3'h0);
    cpu.done(1, r);
    chk("flags bit op", 16'h08, 16'(flags));
    iow(6'h1D, 8'h08);
    chk("flags w1c", 16'h00, 16'(flags));
    iow(OFS_EE_ADDR_LO, 8'h34);
    iow(OFS_EE_ADDR_HI, 8'h01);
    iow(OFS_EE_DATA, 8'h5A);
    lowcnt = 0;
    cpu.ee_write();
    repeat (4) @(posedge core_clk);
    #1;
    chk("write stall", 16'h2, 16'(lowcnt));
    ior(OFS_EE_CTRL, r);
    chk("busy", 16'h1, 16'(r[CTRL_WSTROBE_BIT]));
    wait_idle();
    chk("idle", 16'h0, 16'(r[CTRL_WSTROBE_BIT]));
    iow(OFS_EE_DATA, 8'h00);
    lowcnt = 0;
    iow(OFS_EE_CTRL, 8'h01);
    repeat (6) @(posedge core_clk);
    #1;
    chk("read stall", 16'h4, 16'(lowcnt));
    ior(OFS_EE_DATA, r);
    chk("eeprom byte", 16'h5A, 16'(r));
    iow(OFS_EE_CTRL, 8'h04);
    repeat (6) @(posedge core_clk);
    #1;
    iow(OFS_EE_CTRL, 8'h02);
    ior(OFS_EE_CTRL, r);
    chk("late strobe", 16'h0, 16'(r[CTRL_WSTROBE_BIT]));
    cpu.ee_write();
    nrst = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    ior(OFS_EE_CTRL, r);
    chk("busy over reset", 16'h1, 16'(r[CTRL_WSTROBE_BIT]));
    wait_idle();
    chk("idle after reset", 16'h0, 16'(r[CTRL_WSTROBE_BIT]));
    give_verdict();
  end
endmodule : tb
